// >>> sid_panel_model.sv
// Front panel model: lamps seen by the operator and the address rotary switch
module sid_panel_model
  import sid_pkg::*;
(
  // Switch position chosen by the bench
  input  wire logic [15:0]  setting,
  // Lamp drive from the block
  input  wire sid_leds_type leds,
  // Switch contacts and lamp view
  output logic [15:0]       addr_rotary_switch,
  output logic [6:0]        lit
);
  timeunit 1ns;
  timeprecision 1ps;
  // contacts follow the set position; a real switch bounces, the block resynchronises
  assign addr_rotary_switch = setting;
  // a lamp lights on high drive
  assign lit = leds;
endmodule // sid_panel_model

// >>> sid_pkg.sv
// Shared constants, register map and carrier types for the status indicator driver
package sid_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned TICK_MS       = 1;
  localparam int unsigned CYCLES_PER_MS = CLK_HZ / MS_PER_S * TICK_MS;

  // Indicator timing in milliseconds
  localparam int unsigned NVM_HALF_MS   = 500;
  localparam int unsigned USB_HALF_MS   = 250;
  localparam int unsigned SLOW_HALF_MS  = 750;
  localparam int unsigned FAST_HALF_MS  = 100;
  localparam int unsigned ERR_PULSE_S   = 1;
  localparam int unsigned ERR_PULSE_MS  = ERR_PULSE_S * MS_PER_S;
  localparam int unsigned WARM_STEP_MS  = 200;
  localparam int unsigned WARM_STEPS    = 5;
  localparam int unsigned TMR_W         = 12;

  // Register map, byte addresses
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0]  ADDR_IP       = 8'h10;

  // Field positions and reset values
  localparam int unsigned CTRL_PLX_BIT  = 0;
  localparam logic [31:0] CTRL_RESET    = 32'h0;
  localparam int unsigned IRQ_W         = 3;
  localparam int unsigned IRQ_BUS_BIT   = 0;
  localparam int unsigned IRQ_PLC_BIT   = 1;
  localparam int unsigned IRQ_NVM_BIT   = 2;
  localparam logic [2:0]  IRQ_RESET     = 3'h0;
  localparam int unsigned STAT_WARM_BIT = 7;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // Status inputs from the module's own logic
  typedef struct packed {
    logic nvm_error;
    logic eth_no_response;
    logic usb_console_active;
    logic eth_rx_error;
    logic eth_normal;
    logic bus_error;
    logic plc_error;
    logic link_up;
    logic conn_open;
  } sid_status_type;

  // Front panel indicator drive, high lights the lamp
  typedef struct packed {
    logic power_led;
    logic traffic_led;
    logic alarm_led;
    logic link_led_a;
    logic link_led_b;
    logic line_led;
    logic comm_err_led;
  } sid_leds_type;

endpackage

// >>> sid_pulse.sv
// Retriggerable millisecond pulse timer for one indicator
module sid_pulse
  import sid_pkg::*;
#(
  parameter int unsigned     W   = TMR_W,
  parameter logic [W-1:0]    LEN = W'(ERR_PULSE_MS)
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Time base and event
  input  wire logic ms_tick,
  input  wire logic trigger,
  // Pulse output
  output logic      active
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;

  // Next count: a new event reloads the full length
  always_comb begin
    next_count = count;
    if (trigger) begin
      next_count = LEN;
    end else if (ms_tick && count != '0) begin
      next_count = count - W'(1);
    end
  end

  // Register the count and the pulse level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count  <= '0;
      active <= 1'b0;
    end else begin
      count  <= next_count;
      active <= (next_count != '0);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_pulse_retrig: assert property (trigger |=> (count == LEN) && active)
    else $error("pulse not reloaded by trigger");
  chk_pulse_bound: assert property (count <= LEN)
    else $error("pulse count above length");

endmodule // sid_pulse

// >>> sid_top.sv
// Front-panel status indicator driver with AXI4-Lite registers and interrupt
// Operation
// - Power lamp is steady on, and blinks 500 ms on / 500 ms off while a memory error is flagged.
// - Traffic lamp stays dark while the peer gives no response or the USB console is in use.
// - Traffic lamp blinks at the slow rate while a reception error is flagged.
// - Traffic lamp blinks at the fast rate while Ethernet traffic is normal.
// - Each internal-bus error lights the alarm lamp for one 1 s pulse.
// - While programless PLC exchange is in use the bus-error alarm pulse is suppressed.
// - While powered from a PC over USB the alarm lamp blinks 250 ms on / 250 ms off.
// - Link lamp A follows the link state and link lamp B is always dark.
// - Line lamp is lit while an Ethernet connection is open.
// - Comm error lamp is dark without errors and gives a 1 s pulse on each PLC protocol error.
// - After reset a warm-up lights each lamp but the link lamps in turn before normal display.
// - The rotary switch supplies the third and fourth IP address bytes.
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
module sid_top
  import sid_pkg::*;
#(
  parameter int unsigned MS_CYCLES    = CYCLES_PER_MS,
  parameter int unsigned SLOW_HALF    = SLOW_HALF_MS,
  parameter int unsigned FAST_HALF    = FAST_HALF_MS,
  parameter int unsigned WARM_STEP    = WARM_STEP_MS
) (
  // Clock and reset
  input  wire logic           aclk,
  input  wire logic           aresetn,
  // AXI4-Lite write channels
  input  wire logic [7:0]     s_axi_awaddr,
  input  wire logic           s_axi_awvalid,
  output logic                s_axi_awready,
  input  wire logic [31:0]    s_axi_wdata,
  input  wire logic [3:0]     s_axi_wstrb,
  input  wire logic           s_axi_wvalid,
  output logic                s_axi_wready,
  output logic [1:0]          s_axi_bresp,
  output logic                s_axi_bvalid,
  input  wire logic           s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]     s_axi_araddr,
  input  wire logic           s_axi_arvalid,
  output logic                s_axi_arready,
  output logic [31:0]         s_axi_rdata,
  output logic [1:0]          s_axi_rresp,
  output logic                s_axi_rvalid,
  input  wire logic           s_axi_rready,
  // Module status and pins
  input  wire sid_status_type status,
  input  wire logic           usb_power_pin,
  input  wire logic [15:0]    addr_rotary_switch,
  // Indicators, address and interrupt
  output sid_leds_type        leds,
  output logic [15:0]         ip_addr_bytes,
  output logic                irq
);

  localparam int unsigned MS_W = $clog2(MS_CYCLES);
  localparam logic [TMR_W-1:0] HALF_TAB [4] = '{TMR_W'(NVM_HALF_MS), TMR_W'(USB_HALF_MS),
                                                TMR_W'(SLOW_HALF), TMR_W'(FAST_HALF)};
  localparam logic [TMR_W-1:0] STEP_LEN = TMR_W'(WARM_STEP);

  typedef enum logic {WARM, RUN} sid_state_type;

  // Millisecond divider
  logic [MS_W-1:0] ms_cnt;
  logic [MS_W-1:0] next_ms_cnt;
  logic            ms_tick;
  logic            next_ms_tick;

  always_comb begin
    next_ms_tick = (ms_cnt == MS_W'(MS_CYCLES - 1));
    next_ms_cnt  = next_ms_tick ? '0 : ms_cnt + MS_W'(1);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ms_cnt  <= '0;
      ms_tick <= 1'b0;
    end else begin
      ms_cnt  <= next_ms_cnt;
      ms_tick <= next_ms_tick;
    end
  end

  // Blink generators: 0 memory error, 1 USB power, 2 slow, 3 fast
  logic [3:0] blink;
  for (genvar g = 0; g < 4; g++) begin : g_blink
    logic [TMR_W-1:0] cnt;
    logic [TMR_W-1:0] next_cnt;
    logic             ph;
    logic             next_ph;
    // Phase kept local so each vector bit has a single driver
    assign blink[g] = ph;
    always_comb begin
      next_cnt = cnt;
      next_ph  = ph;
      if (ms_tick) begin
        if (cnt == HALF_TAB[g] - TMR_W'(1)) begin
          next_cnt = '0;
          next_ph  = ~ph;
        end else begin
          next_cnt = cnt + TMR_W'(1);
        end
      end
    end
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt <= '0;
        ph  <= 1'b1;
      end else begin
        cnt <= next_cnt;
        ph  <= next_ph;
      end
    end
  end

  // Pin synchronisers; first stages feed only the second stages
  logic        usb_meta, usb_power;
  logic [15:0] sw_meta, sw_sync;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      usb_meta  <= 1'b0;
      usb_power <= 1'b0;
      sw_meta   <= 16'h0;
      sw_sync   <= 16'h0;
    end else begin
      usb_meta  <= usb_power_pin;
      usb_power <= usb_meta;
      sw_meta   <= addr_rotary_switch;
      sw_sync   <= sw_meta;
    end
  end

  // Register state
  logic [31:0]      ctrl;
  logic [IRQ_W-1:0] irq_stat, irq_mask;
  logic             nvm_prev;
  logic             plx_on;
  assign plx_on = ctrl[CTRL_PLX_BIT];

  // Error pulses
  logic alarm_pulse, err_pulse, bus_trig;
  assign bus_trig = status.bus_error && !plx_on;
  sid_pulse #(.W(TMR_W), .LEN(TMR_W'(ERR_PULSE_MS))) u_alarm_pulse (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ms_tick (ms_tick),
    .trigger (bus_trig),
    .active  (alarm_pulse)
  );
  sid_pulse #(.W(TMR_W), .LEN(TMR_W'(ERR_PULSE_MS))) u_err_pulse (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ms_tick (ms_tick),
    .trigger (status.plc_error),
    .active  (err_pulse)
  );

  // Warm-up sequencer and indicator drive
  sid_state_type    state, next_state;
  logic [2:0]       step, next_step;
  logic [TMR_W-1:0] step_cnt, next_step_cnt;
  sid_leds_type     next_leds;

  always_comb begin
    next_state    = state;
    next_step     = step;
    next_step_cnt = step_cnt;
    next_leds     = '0;
    next_leds.link_led_a = status.link_up;
    next_leds.link_led_b = 1'b0;
    unique case (state)
      WARM: begin
        next_leds.power_led    = (step == 3'h0);
        next_leds.traffic_led  = (step == 3'h1);
        next_leds.alarm_led    = (step == 3'h2);
        next_leds.line_led     = (step == 3'h3);
        next_leds.comm_err_led = (step == 3'h4);
        if (ms_tick) begin
          if (step_cnt == STEP_LEN - TMR_W'(1)) begin
            next_step_cnt = '0;
            if (step == 3'(WARM_STEPS - 1)) begin
              next_state = RUN;
            end else begin
              next_step = step + 3'h1;
            end
          end else begin
            next_step_cnt = step_cnt + TMR_W'(1);
          end
        end
      end
      RUN: begin
        next_leds.power_led = status.nvm_error ? blink[0] : 1'b1;
        if (status.eth_no_response || status.usb_console_active) begin
          next_leds.traffic_led = 1'b0;
        end else if (status.eth_rx_error) begin
          next_leds.traffic_led = blink[2];
        end else begin
          next_leds.traffic_led = status.eth_normal && blink[3];
        end
        // USB power blink wins over pulse
        next_leds.alarm_led    = usb_power ? blink[1] : alarm_pulse;
        next_leds.line_led     = status.conn_open;
        next_leds.comm_err_led = err_pulse;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state    <= WARM;
      step     <= 3'h0;
      step_cnt <= '0;
      leds     <= '0;
    end else begin
      state    <= next_state;
      step     <= next_step;
      step_cnt <= next_step_cnt;
      leds     <= next_leds;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ip_addr_bytes <= 16'h0;
    end else begin
      ip_addr_bytes <= sw_sync;
    end
  end

  // AXI4-Lite slave: address and data held until both arrive
  logic        aw_hold, w_hold, wr_go;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [31:0] w_mask;
  logic [31:0] rd_mux;
  logic        rd_ok;
  logic [IRQ_W-1:0] ev, next_irq_stat, next_irq_mask, w1c;
  logic [31:0] next_ctrl;

  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go         = aw_hold && w_hold;
  assign irq           = |(irq_stat & irq_mask);

  // Register update; a new event beats a same-cycle clear
  always_comb begin
    ev[IRQ_BUS_BIT] = status.bus_error;
    ev[IRQ_PLC_BIT] = status.plc_error;
    ev[IRQ_NVM_BIT] = status.nvm_error && !nvm_prev;
    w1c             = '0;
    next_ctrl       = ctrl;
    next_irq_mask   = irq_mask;
    if (wr_go) begin
      unique case (aw_addr)
        ADDR_CTRL:     next_ctrl     = (ctrl & ~w_mask) | (w_data & w_mask);
        ADDR_IRQ_STAT: w1c           = w_data[IRQ_W-1:0] & w_mask[IRQ_W-1:0];
        ADDR_IRQ_MASK: next_irq_mask = (irq_mask & ~w_mask[IRQ_W-1:0]) | (w_data[IRQ_W-1:0] & w_mask[IRQ_W-1:0]);
        default: ;
      endcase
    end
    next_irq_stat = (irq_stat & ~w1c) | ev;
  end

  // Lane mask from the strobes held with the data; the master may drop wstrb once W is taken
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      w_mask[8*b +: 8] = {8{w_strb[b]}};
    end
  end

  // Read decode; unmapped addresses answer SLVERR with zero data
  always_comb begin
    rd_mux = 32'h0;
    rd_ok  = 1'b1;
    unique case (s_axi_araddr)
      ADDR_CTRL:     rd_mux = ctrl;
      ADDR_STATUS:   rd_mux = {24'h0, state == RUN, leds};
      ADDR_IRQ_STAT: rd_mux = {29'h0, irq_stat};
      ADDR_IRQ_MASK: rd_mux = {29'h0, irq_mask};
      ADDR_IP:       rd_mux = {16'h0, sw_sync};
      default:       rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold      <= 1'b0;
      w_hold       <= 1'b0;
      aw_addr      <= 8'h0;
      w_data       <= 32'h0;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= 32'h0;
      ctrl         <= CTRL_RESET;
      irq_stat     <= IRQ_RESET;
      irq_mask     <= IRQ_RESET;
      nvm_prev     <= 1'b0;
    end else begin
      ctrl     <= next_ctrl;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      nvm_prev <= status.nvm_error;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == ADDR_CTRL || aw_addr == ADDR_IRQ_STAT || aw_addr == ADDR_IRQ_MASK ||
                         aw_addr == ADDR_STATUS || aw_addr == ADDR_IP) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_tick_spacing: assert property (ms_tick |=> !ms_tick)
    else $error("ms tick lasted more than one cycle");
  chk_alarm_pulse: assert property ((state == RUN && !usb_power && bus_trig) |=> ##1 leds.alarm_led)
    else $error("alarm lamp missed bus error pulse");
  chk_plx_suppress: assert property ((plx_on && !alarm_pulse) |=> !alarm_pulse)
    else $error("bus error pulse not suppressed");
  chk_link_b_dark: assert property (!leds.link_led_b)
    else $error("link lamp b lit");
  chk_link_a_follow: assert property (##1 (leds.link_led_a == $past(status.link_up)))
    else $error("link lamp a not following link");
  chk_traffic_dark: assert property ((state == RUN && status.eth_no_response) |=> !leds.traffic_led)
    else $error("traffic lamp lit without response");
  chk_power_steady: assert property ((state == RUN && !status.nvm_error) |=> leds.power_led)
    else $error("power lamp not steady");
  chk_line_follow: assert property ((state == RUN && status.conn_open) |=> leds.line_led)
    else $error("line lamp not lit on connection");
  chk_warm_onehot: assert property ((state == WARM) |=> $onehot0({leds.power_led, leds.traffic_led,
                                     leds.alarm_led, leds.line_led, leds.comm_err_led}))
    else $error("warm-up lit more than one lamp");
  chk_ip_follow: assert property (##1 (ip_addr_bytes == $past(sw_sync)))
    else $error("ip bytes not following switch");
  chk_write_resp: assert property (wr_go |=> s_axi_bvalid)
    else $error("write response missing");

endmodule // sid_top

// >>> tb_top.sv
// Self-checking bench for the status indicator driver
module tb_top
  import sid_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Short time base keeps the 1 s pulses to some 10000 cycles
  localparam int MS = 10;
  localparam int SLOW = 6;
  localparam int FAST = 2;
  localparam int WARM = 3;
  logic           aclk, aresetn, irq;
  logic [7:0]     awaddr, araddr;
  logic           awvalid, awready, wvalid, wready, bvalid, bready;
  logic           arvalid, arready, rvalid, rready, usb_pin;
  logic [31:0]    wdata, rdata, seed;
  logic [1:0]     bresp, rresp;
  logic [3:0]     strb;
  sid_status_type st;
  sid_leds_type   leds;
  logic [15:0]    sw_set, sw_pin, ip;
  logic [6:0]     lit;
  logic [6:0]     warm_exp [5] = '{7'h40, 7'h20, 7'h10, 7'h02, 7'h01};
  logic [1:0]     bq [$];
  logic [1:0]     rq_r [$];
  logic [31:0]    rq_d [$];
  logic [31:0]    rq_m [$];
  int             bad_count, checks_done, n;

  sid_top #(.MS_CYCLES(MS), .SLOW_HALF(SLOW), .FAST_HALF(FAST), .WARM_STEP(WARM)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .status(st),
    .usb_power_pin(usb_pin), .addr_rotary_switch(sw_pin), .leds(leds), .ip_addr_bytes(ip), .irq(irq));

  sid_panel_model panel (.setting(sw_set), .leds(leds), .addr_rotary_switch(sw_pin), .lit(lit));

  // 25 MHz clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    checks_done++;
    if (g < lo || g > hi) begin
      bad_count++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  // Bus write: both channels offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bit ta, tw;
    ta = 0;
    tw = 0;
    bq.push_back(r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ta = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        tw = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r);
    rq_d.push_back(e);
    rq_m.push_back(m);
    rq_r.push_back(r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // Answers are matched against the oldest note of the driver
  always @(posedge aclk) begin
    if (bvalid && bready) chk("bresp", 32'(bq.pop_front()), 32'(bresp));
    if (rvalid && rready) begin
      chk("rdata", rq_d.pop_front(), rdata & rq_m.pop_front());
      chk("rresp", 32'(rq_r.pop_front()), 32'(rresp));
    end
  end

  task automatic wait_lvl(input int b, input logic v);
    while (lit[b] !== v) @(posedge aclk);
  endtask

  task automatic hold_len(input int b, output int c);
    c = 0;
    while (lit[b] === 1'b1) begin
      @(posedge aclk);
      c++;
    end
  endtask

  // Skips a partial phase so that only a whole lit phase is counted
  task automatic measure(input int b, output int c);
    wait_lvl(b, 1'b0);
    wait_lvl(b, 1'b1);
    hold_len(b, c);
  endtask

  task automatic lit_cycles(input int b, input int span, output int c);
    c = 0;
    repeat (2) @(posedge aclk);
    repeat (span) begin
      @(posedge aclk);
      c += int'(lit[b] === 1'b1);
    end
  endtask

  // One-cycle event: bus error or PLC protocol error
  task automatic ev(input bit plc);
    if (plc) st.plc_error <= 1'b1;
    else st.bus_error <= 1'b1;
    @(posedge aclk);
    st.plc_error <= 1'b0;
    st.bus_error <= 1'b0;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog, about one and a half times the expected run
  initial begin
    repeat (90000) @(posedge aclk);
    bad_count++;
    report_and_stop();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, usb_pin} = '0;
    {awaddr, araddr, wdata, st, sw_set} = '0;
    bad_count = 0;
    checks_done = 0;
    seed = 32'h7946;
    strb = 4'hf;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (1) @(posedge aclk);
    for (int k = 0; k < 5; k++) begin
      repeat (k == 0 ? 15 : WARM * MS) @(posedge aclk);
      chk("warm", 32'(warm_exp[k]), 32'(lit));
    end
    repeat (60) @(posedge aclk);
    chk("power", 32'h1, 32'(lit[6]));
    rd(ADDR_STATUS, 32'h80, 32'h80, RESP_OKAY);
    rd(ADDR_CTRL, 32'h0, 32'hffffffff, RESP_OKAY);
    rd(ADDR_IRQ_MASK, 32'h0, 32'h7, RESP_OKAY);
    seed = xs(seed);
    sw_set <= seed[15:0];
    seed = xs(seed);
    wr(ADDR_CTRL, seed, RESP_OKAY);
    rd(ADDR_CTRL, seed, 32'hffffffff, RESP_OKAY);
    // Only the two low lanes are written
    strb <= 4'h3;
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    strb <= 4'hf;
    rd(ADDR_CTRL, seed & 32'hffff0000, 32'hffffffff, RESP_OKAY);
    chk("ip", 32'(sw_set), 32'(ip));
    wr(ADDR_IP, ~seed, RESP_OKAY);
    rd(ADDR_IP, 32'(sw_set), 32'hffff, RESP_OKAY);
    rd(8'h20, 32'h0, 32'hffffffff, RESP_SLVERR);
    wr(8'h20, seed, RESP_SLVERR);
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    st.link_up <= 1'b1;
    st.conn_open <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("link", 32'h5, 32'(lit[3:1]));
    st <= '0;
    repeat (3) @(posedge aclk);
    chk("link", 32'h0, 32'(lit[3:1]));
    st.eth_normal <= 1'b1;
    // Let the new mode reach the lamp so a partial phase is skipped, not timed
    repeat (4) @(posedge aclk);
    measure(5, n);
    chk("fast", 32'(FAST * MS), 32'(n));
    st.eth_rx_error <= 1'b1;
    repeat (4) @(posedge aclk);
    measure(5, n);
    chk("slow", 32'(SLOW * MS), 32'(n));
    st.eth_no_response <= 1'b1;
    lit_cycles(5, 200, n);
    chk("no reply", 32'h0, 32'(n));
    st.eth_no_response <= 1'b0;
    st.usb_console_active <= 1'b1;
    lit_cycles(5, 200, n);
    chk("usb console", 32'h0, 32'(n));
    st <= '0;
    wr(ADDR_IRQ_MASK, 32'h7, RESP_OKAY);
    st.nvm_error <= 1'b1;
    measure(6, n);
    chk("memory blink", 32'(NVM_HALF_MS * MS), 32'(n));
    rd(ADDR_IRQ_STAT, 32'h4, 32'h4, RESP_OKAY);
    chk("irq", 32'h1, 32'(irq));
    wr(ADDR_IRQ_STAT, 32'h4, RESP_OKAY);
    chk("irq", 32'h0, 32'(irq));
    st.nvm_error <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("power", 32'h1, 32'(lit[6]));
    ev(1'b0);
    measure(4, n);
    // A pulse spans 1000 ticks from a tick phase the event does not know
    chk_rng("alarm pulse", 999 * MS + 1, 1000 * MS, n);
    ev(1'b0);
    repeat (5000) @(posedge aclk);
    ev(1'b0);
    hold_len(4, n);
    chk_rng("retrigger", 999 * MS + 3, 1000 * MS + 2, n);
    wr(ADDR_IRQ_STAT, 32'h1, RESP_OKAY);
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    ev(1'b0);
    lit_cycles(4, 200, n);
    chk("suppressed", 32'h0, 32'(n));
    rd(ADDR_IRQ_STAT, 32'h1, 32'h1, RESP_OKAY);
    wr(ADDR_IRQ_STAT, 32'h1, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    wr(ADDR_IRQ_MASK, 32'h0, RESP_OKAY);
    ev(1'b1);
    measure(0, n);
    chk_rng("comm err pulse", 999 * MS + 1, 1000 * MS, n);
    chk("irq masked", 32'h0, 32'(irq));
    wr(ADDR_IRQ_MASK, 32'h7, RESP_OKAY);
    chk("irq", 32'h1, 32'(irq));
    wr(ADDR_IRQ_STAT, 32'h2, RESP_OKAY);
    chk("irq", 32'h0, 32'(irq));
    usb_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    measure(4, n);
    chk("usb blink", 32'(USB_HALF_MS * MS), 32'(n));
    usb_pin <= 1'b0;
    repeat (4) @(posedge aclk);
    report_and_stop();
  end
endmodule // tb_top
